// [bench/lbg_guard_regs_tb.sv]
`timescale 1ns/1ns
module lbg_guard_regs_tb;
  import lbg_pkg::*;
  logic        sys_clk, reset_n, reg_wr_en, reg_rd_en;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [11:0] battery_mv;
  logic [1:0]  watchdog_period;
  logic        flash_reduce, watchdog_expired;
  int          fails, tests_run, cyc;

  // short counts keep the run small
  lbg_guard_regs #(.REC_SHORT_CYCLES(32'h8), .REC_LONG_CYCLES(32'h10),
    .WDT_STEP_CYCLES(32'h32)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .battery_mv(battery_mv),
    .watchdog_period(watchdog_period), .flash_reduce(flash_reduce),
    .watchdog_expired(watchdog_expired));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task end_sim;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      $display("BAD %0t run timed out", $time);
      end_sim;
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask : wr

  // read data holds until the next read, so sample a cycle late
  task rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, exp, "read data");
  endtask : rd

  task wait_red(input logic v, input int n);
    for (int i = 0; i < n && flash_reduce !== v; i++) @(negedge sys_clk);
    chk({7'h00, flash_reduce}, {7'h00, v}, "reduce");
  endtask : wait_red

  task hold_red(input logic v, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge sys_clk);
      if (flash_reduce !== v) ok = 1'b0;
    end
    chk({7'h00, ok}, 8'h01, "reduce held");
  endtask : hold_red

  task t_regs;
    rd(ADDR_GUARD_CTRL, 8'h00);
    rd(ADDR_REC_TIMER, 8'h00);
    rd(ADDR_WDT_KICK, 8'h00);
    rd(8'h20, 8'h00);
    wr(ADDR_GUARD_STAT, 8'hFF);
    rd(ADDR_GUARD_STAT, 8'h00);
    wr(ADDR_GUARD_CTRL, 8'h7F);
    rd(ADDR_GUARD_CTRL, 8'h7F);
    wr(ADDR_REC_TIMER, 8'hFF);
    rd(ADDR_REC_TIMER, 8'h03);
    wr(ADDR_REC_TIMER, 8'h00);
    wr(ADDR_GUARD_CTRL, 8'h00);
  endtask : t_regs

  // each period code is one step of 50 cycles more
  task t_wdt;
    chk({7'h00, watchdog_expired}, 8'h01, "unkicked");
    for (int p = 0; p < 4; p++) begin
      watchdog_period = p[1:0];
      wr(ADDR_WDT_KICK, 8'h01);
      rd(ADDR_WDT_KICK, 8'h01);
      rd(ADDR_WDT_KICK, 8'h00);
      chk({7'h00, watchdog_expired}, 8'h00, "kicked");
      repeat ((p + 1) * 50 - 15) @(negedge sys_clk);
      chk({7'h00, watchdog_expired}, 8'h00, "early");
      for (int i = 0; i < 30 && watchdog_expired !== 1'b1; i++)
        @(negedge sys_clk);
      chk({7'h00, watchdog_expired}, 8'h01, "expiry");
    end
  endtask : t_wdt

  task t_guard;
    battery_mv = 12'hB54;
    wr(ADDR_GUARD_CTRL, 8'hB0);
    hold_red(1'b0, 10);
    battery_mv = 12'hA8C;
    wait_red(1'b1, 5);
    rd(ADDR_GUARD_STAT, 8'h80);
    rd(ADDR_GUARD_STAT, 8'h80);
    battery_mv = 12'hB86;
    hold_red(1'b1, 5);
    wait_red(1'b0, 12);
    rd(ADDR_GUARD_STAT, 8'h80);
    rd(ADDR_GUARD_STAT, 8'h00);
    wr(ADDR_REC_TIMER, 8'h01);
    battery_mv = 12'hA8C;
    wait_red(1'b1, 5);
    battery_mv = 12'hB86;
    hold_red(1'b1, 12);
    wait_red(1'b0, 12);
    wr(ADDR_GUARD_CTRL, 8'hB1);
    battery_mv = 12'hA8C;
    wait_red(1'b1, 5);
    battery_mv = 12'hB86;
    hold_red(1'b1, 40);
    battery_mv = 12'hBC2;
    wait_red(1'b0, 25);
    wr(ADDR_GUARD_CTRL, 8'hB3);
    battery_mv = 12'hA8C;
    wait_red(1'b1, 5);
    battery_mv = 12'hF3C;
    hold_red(1'b1, 40);
    wr(ADDR_GUARD_CTRL, 8'h33);
    wait_red(1'b0, 3);
    wr(ADDR_GUARD_CTRL, 8'hFC);
    battery_mv = 12'hD52;
    hold_red(1'b0, 8);
    battery_mv = 12'hD3E;
    wait_red(1'b1, 5);
    wr(ADDR_GUARD_CTRL, 8'h00);
    wait_red(1'b0, 3);
  endtask : t_guard

  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    battery_mv = 12'hF3C;
    watchdog_period = 2'h0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    t_regs;
    t_wdt;
    t_guard;
    end_sim;
  end
endmodule : lbg_guard_regs_tb

// [common/lbg_pkg.sv]
package lbg_pkg;

  // register port addresses
  localparam logic [7:0] ADDR_GUARD_CTRL  = 8'h0D;
  localparam logic [7:0] ADDR_REC_TIMER   = 8'h0E;
  localparam logic [7:0] ADDR_WDT_KICK    = 8'h16;
  localparam logic [7:0] ADDR_GUARD_STAT  = 8'h18;

  // field positions
  localparam int GUARD_EN_BIT    = 7;
  localparam int THR_MSB         = 6;
  localparam int THR_LSB         = 2;
  localparam int HYS_MSB         = 1;
  localparam int HYS_LSB         = 0;
  localparam int TMR_MSB         = 1;
  localparam int TMR_LSB         = 0;
  localparam int KICK_BIT        = 0;
  localparam int FLAG_BIT        = 7;

  // reset values
  localparam logic [7:0] GUARD_CTRL_RST = 8'h00;
  localparam logic [1:0] REC_TIMER_RST  = 2'h0;
  localparam logic [7:0] RD_ZERO        = 8'h00;

  // threshold decode: base plus a third of 100 mV per code
  localparam logic [12:0] THR_BASE_MV  = 13'h0960;
  localparam logic [12:0] THR_STEP_NUM = 13'h0064;
  localparam logic [12:0] THR_STEP_DEN = 13'h0003;
  localparam logic [4:0]  THR_TOP_CODE = 5'h1E;
  localparam logic [4:0]  THR_ALL_ONES = 5'h1F;

  // hysteresis codes and sizes
  localparam logic [1:0]  HYS_100      = 2'h0;
  localparam logic [1:0]  HYS_200      = 2'h1;
  localparam logic [1:0]  HYS_OFF      = 2'h3;
  localparam logic [12:0] HYS_100_MV   = 13'h0064;
  localparam logic [12:0] HYS_200_MV   = 13'h00C8;

  // recovery timer codes
  localparam logic [1:0]  TMR_SHORT    = 2'h0;
  localparam logic [1:0]  TMR_LONG     = 2'h1;

  // timing
  localparam longint CLK_PERIOD_PS   = 4000;
  localparam longint REC_SHORT_PS    = 250000000;
  localparam longint REC_LONG_PS     = 500000000;
  localparam longint WDT_STEP_S      = 4;
  localparam longint PS_PER_S        = 1000000000000;
  localparam longint REC_SHORT_CYC   = REC_SHORT_PS / CLK_PERIOD_PS;
  localparam longint REC_LONG_CYC    = REC_LONG_PS / CLK_PERIOD_PS;
  localparam longint WDT_STEP_CYC    = WDT_STEP_S * PS_PER_S
                                       / CLK_PERIOD_PS;

endpackage : lbg_pkg

// [hw/lbg_guard_regs.sv]
`timescale 1ns/1ns
// How it works
// - guard acts only while enable bit set
// - threshold code maps to 33mV steps, capped
// - hysteresis 100mV, 200mV, or never restore
// - recovery timer code selects 0.25ms or 0.5ms
// - kick restarts watchdog, bit self clears
// - all fields and reserved bits reset zero
// - guard, timer and kick registers readable, writable
// - watchdog timeout 4, 8, 12 or 16 s
// - event flag latched, cleared by status read
module lbg_guard_regs
  import lbg_pkg::*;
#(
  parameter logic [31:0] REC_SHORT_CYCLES = 32'(REC_SHORT_CYC),
  parameter logic [31:0] REC_LONG_CYCLES  = 32'(REC_LONG_CYC),
  parameter logic [31:0] WDT_STEP_CYCLES  = 32'(WDT_STEP_CYC)
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rdata,
  input  wire logic [11:0] battery_mv,
  input  wire logic [1:0]  watchdog_period,
  output logic             flash_reduce,
  output logic             watchdog_expired
);

  logic        rst_meta_ff;
  logic        rst_sync_ff;
  logic [11:0] batt_meta_ff;
  logic [11:0] batt_ff;
  logic [7:0]  ctrl_ff;
  logic [1:0]  tmr_ff;
  logic        kick_ff;
  logic        flag_ff;
  logic        reduce_ff;
  logic        expired_ff;
  logic [7:0]  rdata_ff;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // adc word is assumed to settle well before two clocks pass
  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      batt_meta_ff <= '0;
      batt_ff      <= '0;
    end else begin
      batt_meta_ff <= battery_mv;
      batt_ff      <= batt_meta_ff;
    end
  end

  // register decode
  wire sel_ctrl = (reg_addr == ADDR_GUARD_CTRL);
  wire sel_tmr  = (reg_addr == ADDR_REC_TIMER);
  wire sel_kick = (reg_addr == ADDR_WDT_KICK);
  wire sel_stat = (reg_addr == ADDR_GUARD_STAT);
  wire wr_ctrl  = reg_wr_en && sel_ctrl;
  wire wr_tmr   = reg_wr_en && sel_tmr;
  wire wr_kick  = reg_wr_en && sel_kick && reg_wdata[KICK_BIT];
  wire rd_stat  = reg_rd_en && sel_stat;

  wire       guard_en = ctrl_ff[GUARD_EN_BIT];
  wire [4:0] thr_code = ctrl_ff[THR_MSB:THR_LSB];
  wire [1:0] hys_code = ctrl_ff[HYS_MSB:HYS_LSB];

  // two top codes share the highest level
  wire [4:0]  thr_sat = (thr_code == THR_ALL_ONES) ? THR_TOP_CODE
                                                   : thr_code;
  wire [12:0] thr_mv  = THR_BASE_MV
                        + ({8'h00, thr_sat} * THR_STEP_NUM)
                        / THR_STEP_DEN;
  // reserved hysteresis code falls back to the smaller step
  wire [12:0] hys_mv  = (hys_code == HYS_200) ? HYS_200_MV
                                              : HYS_100_MV;
  wire [12:0] batt13  = {1'b0, batt_ff};
  wire        below   = batt13 < thr_mv;
  wire        above   = batt13 > (thr_mv + hys_mv);
  wire        can_restore = (hys_code != HYS_OFF);

  // reserved timer codes use the short period
  wire [31:0] rec_load = ((tmr_ff == TMR_LONG) ? REC_LONG_CYCLES
                                               : REC_SHORT_CYCLES)
                         - 32'h1;
  wire        rec_run  = guard_en && reduce_ff && above && can_restore;
  wire        rec_done;

  lbg_timer #(.W(32)) u_rec_timer (
    .clk     (sys_clk),
    .rst_n   (rst_sync_ff),
    .restart (!rec_run),
    .load    (rec_load),
    .done    (rec_done)
  );

  // 16 s needs the full 32 bits, so widen before the product
  // the multiplier needs a third bit or code 11 would wrap to zero
  wire [2:0]  wdt_mult = {1'b0, watchdog_period} + 3'h1;
  wire [33:0] wdt_prod = {2'b00, WDT_STEP_CYCLES} * {31'h0, wdt_mult};
  wire [31:0] wdt_load = wdt_prod[31:0] - 32'h1;
  wire        wdt_done;

  lbg_timer #(.W(32)) u_wdt_timer (
    .clk     (sys_clk),
    .rst_n   (rst_sync_ff),
    .restart (kick_ff),
    .load    (wdt_load),
    .done    (wdt_done)
  );

  wire       nxt_reduce = guard_en
                          && ((below || reduce_ff) && !rec_done);
  wire       flag_set   = guard_en && below;
  wire       nxt_flag   = flag_set || (flag_ff && !rd_stat);
  wire       nxt_kick   = wr_kick;
  wire       nxt_expired = wdt_done && !kick_ff;
  wire [7:0] nxt_rdata  = sel_ctrl ? ctrl_ff
                        : sel_tmr  ? {6'h00, tmr_ff}
                        : sel_kick ? {7'h00, kick_ff}
                        : sel_stat ? {flag_ff, 7'h00}
                        : RD_ZERO;

  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl_ff <= GUARD_CTRL_RST;
      tmr_ff  <= REC_TIMER_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata;
      end
      if (wr_tmr) begin
        tmr_ff <= reg_wdata[TMR_MSB:TMR_LSB];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      kick_ff    <= 1'b0;
      flag_ff    <= 1'b0;
      reduce_ff  <= 1'b0;
      expired_ff <= 1'b0;
      rdata_ff   <= RD_ZERO;
    end else begin
      kick_ff    <= nxt_kick;
      flag_ff    <= nxt_flag;
      reduce_ff  <= nxt_reduce;
      expired_ff <= nxt_expired;
      if (reg_rd_en) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign reg_rdata        = rdata_ff;
  assign flash_reduce     = reduce_ff;
  assign watchdog_expired = expired_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_ff);

  a_guard_off_clears: assert property (
    !guard_en |=> !reduce_ff)
    else $error("guard disabled but reduction active");

  a_thr_decode_pts: assert property (
    (thr_code == 5'h0C |-> thr_mv == 13'h0AF0)
    and (thr_code == 5'h1F |-> thr_mv == 13'h0D48))
    else $error("threshold decode wrong");

  a_hys_off_holds: assert property (
    guard_en && reduce_ff && hys_code == HYS_OFF ##1 guard_en
    |-> reduce_ff)
    else $error("reduction restored with hysteresis off");

  a_tmr_load_sel: assert property (
    tmr_ff == TMR_LONG |-> rec_load == REC_LONG_CYCLES - 32'h1)
    else $error("recovery timer select wrong");

  a_kick_self_clr: assert property (
    wr_kick ##1 !wr_kick |-> kick_ff ##1 !kick_ff)
    else $error("kick bit not set then cleared");

  a_resv_read_zero: assert property (
    reg_rd_en && (sel_tmr || sel_kick) |=> rdata_ff[7:2] == 6'h00)
    else $error("reserved bits read nonzero");

  a_ctrl_write_read: assert property (
    wr_ctrl ##1 (reg_rd_en && sel_ctrl && !reg_wr_en)
    |=> rdata_ff == $past(reg_wdata, 2))
    else $error("control register readback wrong");

  a_wdt_period_sel: assert property (
    watchdog_period == 2'h3
    |-> wdt_load == WDT_STEP_CYCLES * 32'h4 - 32'h1)
    else $error("watchdog period select wrong");

  a_flag_set_wins: assert property (
    flag_set && rd_stat |=> flag_ff)
    else $error("event flag lost on read");

  a_recover_rel: assert property (
    $fell(reduce_ff) |-> !$past(guard_en) || $past(rec_done))
    else $error("reduction released without recovery");

endmodule : lbg_guard_regs

// [hw/lbg_timer.sv]
`timescale 1ns/1ns
module lbg_timer #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         restart,
  input  wire logic [W-1:0] load,
  output logic              done
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  wire          at_zero = (cnt_ff == '0);

  // restart reloads; otherwise count down and park at zero
  assign nxt_cnt = restart ? load : (at_zero ? cnt_ff : cnt_ff - 1'b1);
  assign done    = at_zero && !restart;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : lbg_timer
